//--- bench/irq_vector_and_sleep_control_test.sv
`timescale 1ns/1ns
module irq_vector_and_sleep_control_test;
  import ivs_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, hdone = 0;
  logic cpu_ack, cpu_reti, irq_req, pready, pslverr, in_h, er;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic [15:0] irq_vector, vec_seen;
  logic [7:0] me1, me2;
  ivs_sys_t sys_evt = '0;
  ivs_periph_t periph_flags = '0;
  ivs_clk_t clk_ctrl;
  int failures = 0, cmp_count = 0, cyc = 0, b, h;
  int lo[9] = '{34, 29, 28, 21, 20, 17, 9, 1, 0};
  int wd[9] = '{1, 5, 1, 7, 1, 3, 8, 8, 1};
  logic [3:0] pr[9] = '{4'hD, 4'hC, 4'hB, 4'h9, 4'h6, 4'h5, 4'h4, 4'h1, 4'h0};
  logic [2:0] md[6] = '{FULL_RUN_MODE, SLEEP_LEVEL_0, SLEEP_LEVEL_1, SLEEP_LEVEL_2, SLEEP_LEVEL_3, SLEEP_LEVEL_4};
  // unlisted clocks per level are left unchecked, hence the masks
  logic [7:0] mk[6] = '{8'hFF, 8'hF8, 8'hF8, 8'hDE, 8'hDE, 8'hDF};
  logic [7:0] vl[6] = '{8'hFF, 8'h78, 8'h70, 8'h12, 8'h10, 8'h00};
  logic [7:0] se[4] = '{8'h20, 8'h40, 8'h10, 8'h80};
  ivs_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sys_evt(sys_evt),
    .periph_flags(periph_flags), .cpu_ack(cpu_ack), .cpu_reti(cpu_reti), .irq_req(irq_req),
    .irq_vector(irq_vector), .clk_ctrl(clk_ctrl), .module_enable_1(me1), .module_enable_2(me2));
  ivs_cpu_model cpu (.pclk(pclk), .presetn(presetn), .irq_req(irq_req), .irq_vector(irq_vector), .hdone(hdone),
    .cpu_ack(cpu_ack), .cpu_reti(cpu_reti), .in_h(in_h), .vec_seen(vec_seen));
  // ==========================================
  // helpers
  initial forever #10 pclk = ~pclk;
  function automatic logic [34:0] grp(int k);
    return ((35'h1 << wd[k]) - 35'h1) << lo[k];
  endfunction
  function automatic logic [34:0] one(int k);
    return 35'h1 << (lo[k] + $urandom_range(wd[k] - 1));
  endfunction
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [11:0] i, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= {18'h0, i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task serve(input logic [3:0] p, input logic [34:0] clr);
    wait (in_h === 1'b1);
    periph_flags <= ivs_periph_t'(periph_flags & ~clr);
    // the core is woken one edge after it takes the vector
    @(posedge pclk);
    @(negedge pclk);
    chk("vector", {16'h0, vec_seen}, {16'h0, VEC_BASE + {11'h0, p, 1'b0}});
    chk("cpu_run", 32'(clk_ctrl.cpu_run), 32'h1);
    apb(1, IDX_INTERRUPT_FLAG_1_2, 32'h0);
    hdone <= 1;
    @(posedge pclk);
    hdone <= 0;
    wait (in_h === 1'b0);
  endtask
  task pulse(input logic [7:0] s);
    @(posedge pclk);
    sys_evt <= ivs_sys_t'(s);
    @(posedge pclk);
    sys_evt <= '0;
  endtask
  task conclude;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // the whole run needs a few hundred cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      conclude;
    end
  end
  // ==========================================
  // tests
  initial begin
    void'($urandom(32'hB0383E20));
    repeat (20) @(posedge pclk);
    presetn <= 1;
    for (int k = 0; k < 2; k++) begin
      apb(0, k ? IDX_MODULE_ENABLE_2 : IDX_MODULE_ENABLE_1, 32'h0);
      chk("me reset", rd, 32'h0);
      h = $urandom_range(255);
      apb(1, k ? IDX_MODULE_ENABLE_2 : IDX_MODULE_ENABLE_1, 32'(h));
      @(negedge pclk);
      chk("me port", 32'(k ? me2 : me1), 32'(h));
    end
    apb(1, IDX_INTERRUPT_ENABLE_1_2, 32'hFF);
    apb(0, IDX_INTERRUPT_ENABLE_1_2, 32'h0);
    chk("ie bits", rd, 32'(IE_IMPL));
    apb(0, 12'h0FF, 32'h0);
    chk("unmapped", {rd[30:0], er}, 32'h1);
    $display("registers done");
    apb(1, IDX_POWER_CONTROL, 32'h8);
    for (int i = 0; i < 9; i++) begin
      b = $urandom_range(8);
      h = (i < b) ? i : b;
      periph_flags <= ivs_periph_t'(one(i) | one(b));
      serve(pr[h], grp(h));
      if (b != i) serve(pr[i + b - h], grp(i + b - h));
    end
    $display("priority done");
    for (int k = 0; k < 6; k++) begin
      apb(1, IDX_POWER_CONTROL, 32'h8);
      apb(1, IDX_POWER_CONTROL, {28'h0, 1'b1, md[k]});
      repeat (2) @(negedge pclk);
      chk("clocks", 32'(clk_ctrl & mk[k]), 32'(vl[k]));
      if (k > 0) begin
        periph_flags <= ivs_periph_t'(35'h1);
        serve(4'h0, 35'h1);
        repeat (3) @(negedge pclk);
        chk("clocks back", 32'(clk_ctrl & mk[k]), 32'(vl[k]));
      end
    end
    $display("sleep done");
    apb(1, IDX_POWER_CONTROL, 32'h20);
    apb(1, IDX_INTERRUPT_ENABLE_1_2, 32'h10);
    pulse(8'h08);
    serve(4'hE, 35'h0);
    pulse(8'h04);
    repeat (5) @(negedge pclk);
    chk("masked", 32'(irq_req), 32'h0);
    apb(0, IDX_INTERRUPT_FLAG_1_2, 32'h0);
    chk("osc flag", rd, 32'h2);
    apb(1, IDX_INTERRUPT_ENABLE_1_2, 32'h2);
    serve(4'hE, 35'h0);
    apb(1, IDX_INTERRUPT_ENABLE_1_2, 32'h20);
    pulse(8'h02);
    serve(4'hE, 35'h0);
    $display("shared vector done");
    apb(1, IDX_POWER_CONTROL, 32'h0);
    apb(1, IDX_INTERRUPT_ENABLE_1_2, 32'h0);
    for (int k = 0; k < 4; k++) begin
      pulse(se[k]);
      serve(4'hF, 35'h0);
      apb(0, IDX_INTERRUPT_FLAG_1_2, 32'h0);
      chk("wdt flag", rd, 32'(~k & 1));
    end
    $display("reset sources done");
    pulse(8'h20);
    serve(4'hF, 35'h0);
    apb(1, IDX_INTERRUPT_ENABLE_1_2, 32'h1);
    apb(1, IDX_POWER_CONTROL, 32'h8);
    repeat (5) @(negedge pclk);
    chk("wdt reset mode", 32'(irq_req), 32'h0);
    apb(1, IDX_POWER_CONTROL, 32'h18);
    serve(4'hA, 35'h0);
    $display("watchdog enable done");
    conclude;
  end
endmodule

//--- bench/ivs_cpu_model.sv
`timescale 1ns/1ns
module ivs_cpu_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic hdone,
  output logic cpu_ack,
  output logic cpu_reti,
  output logic in_h,
  output logic [15:0] vec_seen
);
  // ==========================================
  // core stand-in: random stall before taking a vector, returns when the bench says
  logic [1:0] stall;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_ack <= 1'b0;
      cpu_reti <= 1'b0;
      in_h <= 1'b0;
      vec_seen <= 16'h0000;
      stall <= 2'h0;
    end else begin
      cpu_ack <= 1'b0;
      cpu_reti <= 1'b0;
      if (!in_h && irq_req && !cpu_ack) begin
        if (stall == 2'h0) begin
          cpu_ack <= 1'b1;
          vec_seen <= irq_vector;
          in_h <= 1'b1;
          stall <= 2'($urandom);
        end else begin
          stall <= stall - 2'h1;
        end
      end else if (in_h && hdone) begin
        // no nesting: a second request waits until this return
        cpu_reti <= 1'b1;
        in_h <= 1'b0;
      end
    end
  end
endmodule

//--- bench/ivs_ctrl_assertions.sv
`timescale 1ns/1ns
module ivs_ctrl_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire ivs_pkg::ivs_sys_t sys_evt,
  input wire logic cpu_ack,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire ivs_pkg::ivs_clk_t clk_ctrl
);
  import ivs_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // clock gating per mode and request behaviour
  AST_RUN_ALL: assert property (clk_ctrl.cpu_run |-> clk_ctrl == 8'hFF) else $error("run mode clock off");
  AST_L0: assert property (!clk_ctrl.cpu_run && clk_ctrl.freq_lock_loop_on |->
    clk_ctrl.main_clk_on && clk_ctrl.sub_clk_on && clk_ctrl.aux_clk_on) else $error("level 0 clocks");
  AST_L1: assert property (!clk_ctrl.cpu_run && clk_ctrl.main_clk_on |->
    clk_ctrl.sub_clk_on && clk_ctrl.aux_clk_on) else $error("level 1 clocks");
  AST_L2: assert property (!clk_ctrl.cpu_run && !clk_ctrl.main_clk_on |->
    !clk_ctrl.freq_lock_loop_on && !clk_ctrl.controlled_osc_clock_on) else $error("level 2 clocks");
  AST_L3: assert property (!clk_ctrl.osc_dc_gen_on |->
    !clk_ctrl.cpu_run && !clk_ctrl.main_clk_on && !clk_ctrl.controlled_osc_clock_on) else $error("level 3 clocks");
  AST_L4: assert property (!clk_ctrl.aux_clk_on |->
    !clk_ctrl.crystal_on && !clk_ctrl.osc_dc_gen_on) else $error("level 4 clocks");
  AST_VEC: assert property (irq_req |-> irq_vector[15:5] == 11'h7FF && !irq_vector[0]) else $error("vector range");
  AST_RST: assert property (|sys_evt[7:4] && !cpu_ack |=> irq_req && irq_vector == VEC_RESET)
    else $error("reset vector missing");
  AST_HOLD: assert property (irq_req && !cpu_ack && !(|sys_evt[7:4]) |=> irq_req && $stable(irq_vector))
    else $error("pending request lost");
  AST_WAKE: assert property (cpu_ack && irq_req && irq_vector != VEC_RESET |-> ##[1:2] clk_ctrl.cpu_run)
    else $error("no wake for handler");
  cover property (cpu_ack && irq_vector == VEC_RESET);
  cover property (cpu_ack && irq_vector == 16'hFFFC);
  cover property (!clk_ctrl.aux_clk_on ##1 clk_ctrl.cpu_run);
endmodule
bind ivs_ctrl ivs_ctrl_assertions u_chk (.pclk(pclk), .presetn(presetn), .sys_evt(sys_evt), .cpu_ack(cpu_ack),
  .irq_req(irq_req), .irq_vector(irq_vector), .clk_ctrl(clk_ctrl));

//--- rtl/ivs_ctrl.sv
`timescale 1ns/1ns
module ivs_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ivs_pkg::ivs_sys_t sys_evt,
  input wire ivs_pkg::ivs_periph_t periph_flags,
  input wire logic cpu_ack,
  input wire logic cpu_reti,
  output logic irq_req,
  output logic [15:0] irq_vector,
  output ivs_pkg::ivs_clk_t clk_ctrl,
  output logic [7:0] module_enable_1,
  output logic [7:0] module_enable_2
);
  import ivs_pkg::*;

  // ==========================================
  // registers
  logic [7:0] ie_reg;
  logic [7:0] ifg_reg;
  logic [7:0] me1_reg;
  logic [7:0] me2_reg;
  logic [7:0] pwr_reg;
  ivs_mode_t mode_reg;
  ivs_mode_t saved_mode_reg;
  ivs_state_t state_reg;
  logic [15:0] vec_reg;
  logic [3:0] prio_reg;
  logic req_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  ivs_clk_t clk_reg;

  // ==========================================
  // bus decode
  wire [11:0] idx = paddr[13:2];
  wire aligned = paddr[1:0] == 2'b00;
  wire setup = psel && !penable;
  wire hit_ie = idx == IDX_INTERRUPT_ENABLE_1_2;
  wire hit_ifg = idx == IDX_INTERRUPT_FLAG_1_2;
  wire hit_me1 = idx == IDX_MODULE_ENABLE_1;
  wire hit_me2 = idx == IDX_MODULE_ENABLE_2;
  wire hit_pwr = idx == IDX_POWER_CONTROL;
  wire hit_vs = idx == IDX_VECTOR_STATUS;
  wire hit_set = idx == IDX_FLAG_SET;
  wire mapped = aligned && paddr[31:14] == 18'h00000 &&
                (hit_ie || hit_ifg || hit_me1 || hit_me2 || hit_pwr || hit_vs || hit_set);
  // writes commit in the access cycle, the only cycle pready is high
  wire wr = psel && penable && pready_reg && pwrite && mapped && pstrb[0];
  wire [7:0] wbyte = pwdata[7:0];

  // ==========================================
  // flag sources
  wire wdt_interval_mode = pwr_reg[P_WDT_INTERVAL];
  wire gie = pwr_reg[P_GIE];
  wire reset_evt = sys_evt.power_up | sys_evt.ext_reset | sys_evt.watchdog_expiry |
                   sys_evt.flash_key_violation;
  // watchdog flag: overflow in watchdog mode or key violation; interval tick in interval mode
  wire wdt_set = (sys_evt.watchdog_expiry & ~wdt_interval_mode) | sys_evt.flash_key_violation |
                 (sys_evt.watchdog_interval & wdt_interval_mode);
  wire wdt_hw_clr = sys_evt.power_up | (sys_evt.ext_reset & ~pwr_reg[P_NMI_SEL]);
  wire nmi_set = sys_evt.nmi_pin_event & pwr_reg[P_NMI_SEL];
  wire osc_set = sys_evt.osc_fault;
  wire accv_set = sys_evt.flash_violation;
  wire bt_set = periph_flags.basic_tick;
  logic [7:0] hw_set;
  assign hw_set = {bt_set, 1'b0, accv_set, nmi_set, 2'b00, osc_set, wdt_set};
  wire [7:0] sw_set = (wr && hit_set) ? wbyte : 8'h00;
  // software may clear any flag except the watchdog flag; set beats clear
  wire [7:0] sw_clr = (wr && hit_ifg) ? (~wbyte & ~(8'h01 << B_WDT)) : 8'h00;
  // the watchdog flag only drops on power-up or on the pin reset in reset mode
  wire [7:0] wdt_clr_mask = wdt_hw_clr ? (8'h01 << B_WDT) : 8'h00;
  wire [7:0] ifg_kept = (ifg_reg & ~sw_clr) | hw_set | sw_set;
  // the watchdog, NMI and access-violation sets are ORed in last, so they win over any clear in the same cycle
  wire [7:0] ifg_next = (ifg_kept & IFG_IMPL & ~wdt_clr_mask) |
                        {2'b00, accv_set, nmi_set, 3'b000, wdt_set};

  // ==========================================
  // priority request lines, indexed by priority number
  wire nmi_grp = (ifg_reg[B_NMI] & ie_reg[B_NMI]) | (ifg_reg[B_OSC] & ie_reg[B_OSC]) |
                 (ifg_reg[B_ACCV] & ie_reg[B_ACCV]);
  wire wdt_ok = ifg_reg[B_WDT] & wdt_interval_mode & ie_reg[B_WDT];
  // slots 8, 7, 3 and 2 have no source and are tied off
  logic [N_PRIO-1:0] line;
  assign line[PRIO_RESET] = 1'b0;
  assign line[PRIO_NMI] = nmi_grp;
  assign line[PRIO_T5_C0] = gie & periph_flags.t5_c0;
  assign line[PRIO_T5_SH] = gie & |periph_flags.t5_shared;
  assign line[PRIO_CMP] = gie & periph_flags.comparator_flag;
  assign line[PRIO_WDT] = gie & wdt_ok;
  assign line[PRIO_SCAN] = gie & |periph_flags.scan_if_flags;
  assign line[8] = 1'b0;
  assign line[7] = 1'b0;
  assign line[PRIO_T3_C0] = gie & periph_flags.t3_c0;
  assign line[PRIO_T3_SH] = gie & |periph_flags.t3_shared;
  assign line[PRIO_P1] = gie & |periph_flags.port_one_change_flags;
  assign line[3] = 1'b0;
  assign line[2] = 1'b0;
  assign line[PRIO_P2] = gie & |periph_flags.port_two_change_flags;
  assign line[PRIO_BT] = gie & ifg_reg[B_BT] & ie_reg[B_BT];

  // highest number wins; lower ones stay pending in their flags
  logic [3:0] win;
  logic any;
  always_comb begin
    win = 4'h0;
    any = 1'b0;
    for (int i = 0; i < N_PRIO; i++) begin
      if (line[i]) begin
        win = 4'(i);
        any = 1'b1;
      end
    end
  end
  wire [15:0] win_vec = VEC_BASE + {11'h000, win, 1'b0};

  // ==========================================
  // clock gating per mode
  function automatic ivs_clk_t mode_clk(input ivs_mode_t m);
    ivs_clk_t c;
    c = '1;
    case (m)
      FULL_RUN_MODE: begin
        c = '1;
      end
      SLEEP_LEVEL_0: begin
        c.cpu_run = 1'b0;
      end
      SLEEP_LEVEL_1: begin
        c.cpu_run = 1'b0;
        c.freq_lock_loop_on = 1'b0;
      end
      SLEEP_LEVEL_2: begin
        c = '{cpu_run: 1'b0, main_clk_on: 1'b0, sub_clk_on: 1'b0, aux_clk_on: 1'b1,
              freq_lock_loop_on: 1'b0, controlled_osc_clock_on: 1'b0, osc_dc_gen_on: 1'b1,
              crystal_on: 1'b1};
      end
      SLEEP_LEVEL_3: begin
        c = '{cpu_run: 1'b0, main_clk_on: 1'b0, sub_clk_on: 1'b0, aux_clk_on: 1'b1,
              freq_lock_loop_on: 1'b0, controlled_osc_clock_on: 1'b0, osc_dc_gen_on: 1'b0,
              crystal_on: 1'b1};
      end
      SLEEP_LEVEL_4: begin
        c = '0;
      end
      default: begin
        c = '1;
      end
    endcase
    return c;
  endfunction

  // codes 100 and 101 name no level; they read as full run so that a stray
  // write can never leave the core halted with every clock still on
  wire mode_code_ok = wbyte[2:0] != 3'b100 && wbyte[2:0] != 3'b101;
  wire ivs_mode_t wr_mode = mode_code_ok ? ivs_mode_t'(wbyte[2:0]) : FULL_RUN_MODE;
  wire wr_pwr = wr && hit_pwr;
  wire acked = req_reg && cpu_ack;
  // a new request is latched only while none is pending, so the vector stands until taken or a reset source replaces it
  wire take = any && !req_reg && state_reg != ST_SERVE;

  // ==========================================
  // serve / sleep sequencer
  ivs_state_t state_next;
  ivs_mode_t mode_next;
  always_comb begin
    state_next = state_reg;
    mode_next = mode_reg;
    case (state_reg)
      ST_RUN: begin
        if (acked) begin
          // taking a vector wins over a level write in the same cycle
          state_next = ST_SERVE;
        end else if (wr_pwr && wr_mode != FULL_RUN_MODE) begin
          mode_next = wr_mode;
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (acked) begin
          mode_next = FULL_RUN_MODE;
          state_next = ST_SERVE;
        end else if (wr_pwr) begin
          // a bus master other than the halted core may change the level or wake it
          mode_next = wr_mode;
          state_next = (wr_mode == FULL_RUN_MODE) ? ST_RUN : ST_SLEEP;
        end
      end
      ST_SERVE: begin
        if (cpu_reti) begin
          mode_next = saved_mode_reg;
          state_next = (saved_mode_reg == FULL_RUN_MODE) ? ST_RUN : ST_SLEEP;
        end
      end
      default: begin
        state_next = ST_RUN;
        mode_next = FULL_RUN_MODE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_RUN;
      mode_reg <= FULL_RUN_MODE;
    end else begin
      state_reg <= state_next;
      mode_reg <= mode_next;
    end
  end

  // the level in force when the vector is taken is the one the return restores
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      saved_mode_reg <= FULL_RUN_MODE;
    end else if (acked) begin
      saved_mode_reg <= mode_reg;
    end
  end

  // reset sources override everything and present the reset vector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_reg <= 1'b0;
      vec_reg <= VEC_RESET;
      prio_reg <= PRIO_RESET;
    end else if (reset_evt) begin
      req_reg <= 1'b1;
      vec_reg <= VEC_RESET;
      prio_reg <= PRIO_RESET;
    end else if (req_reg && cpu_ack) begin
      req_reg <= 1'b0;
    end else if (take) begin
      req_reg <= 1'b1;
      vec_reg <= win_vec;
      prio_reg <= win;
    end
  end

  // ==========================================
  // flag and enable registers
  // flags are rewritten every edge, so a hardware set is never lost to a bus clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ifg_reg <= RST_IFG;
    end else begin
      ifg_reg <= ifg_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_reg <= RST_BYTE;
    end else if (wr && hit_ie) begin
      ie_reg <= wbyte & IE_IMPL;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      me1_reg <= RST_BYTE;
    end else if (wr && hit_me1) begin
      me1_reg <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      me2_reg <= RST_BYTE;
    end else if (wr && hit_me2) begin
      me2_reg <= wbyte;
    end
  end

  // only gie, interval mode and pin mode are kept here; the level lives in mode_reg
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_reg <= RST_BYTE;
    end else if (wr_pwr) begin
      pwr_reg <= {2'b00, wbyte[5:3], 3'b000};
    end
  end

  // ==========================================
  // read path and outputs
  logic [7:0] rbyte;
  always_comb begin
    rbyte = 8'h00;
    if (hit_ie) rbyte = ie_reg;
    if (hit_ifg) rbyte = ifg_reg;
    if (hit_me1) rbyte = me1_reg;
    if (hit_me2) rbyte = me2_reg;
    if (hit_pwr) rbyte = {pwr_reg[7:3], mode_reg};
    if (hit_vs) rbyte = {1'b0, state_reg == ST_SERVE, req_reg, 1'b0, prio_reg};
  end

  // no wait state: setup, then access with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup && !mapped;
    end
  end

  // read data is latched in setup, so it stands through the whole access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (setup) begin
      prdata_reg <= (mapped && !pwrite) ? {24'h000000, rbyte} : 32'h00000000;
    end
  end

  // ==========================================
  // clock gating outputs
  // gating follows the next mode, so the clock enables change on the edge that moves the level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_reg <= '1;
    end else begin
      clk_reg <= mode_clk(mode_next);
    end
  end

  // ==========================================
  // outputs

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq_req = req_reg;
  assign irq_vector = vec_reg;
  assign clk_ctrl = clk_reg;
  assign module_enable_1 = me1_reg;
  assign module_enable_2 = me2_reg;
endmodule

//--- rtl/ivs_pkg.sv
package ivs_pkg;
  // ==========================================
  // register map (printed offsets 04h/05h are not word multiples: indexes)
  localparam logic [11:0] IDX_MODULE_ENABLE_1 = 12'h004;
  localparam logic [11:0] IDX_MODULE_ENABLE_2 = 12'h005;
  localparam logic [11:0] IDX_INTERRUPT_ENABLE_1_2 = 12'h000;
  localparam logic [11:0] IDX_INTERRUPT_FLAG_1_2 = 12'h002;
  localparam logic [11:0] IDX_POWER_CONTROL = 12'h008;
  localparam logic [11:0] IDX_VECTOR_STATUS = 12'h009;
  localparam logic [11:0] IDX_FLAG_SET = 12'h00A;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_IFG = 8'h00;
  // interrupt enable / flag bit positions
  localparam int B_WDT = 0;
  localparam int B_OSC = 1;
  localparam int B_NMI = 4;
  localparam int B_ACCV = 5;
  localparam int B_BT = 7;
  localparam logic [7:0] IE_IMPL = 8'hB3;
  localparam logic [7:0] IFG_IMPL = 8'h93;
  // power control fields
  localparam int P_GIE = 3;
  localparam int P_WDT_INTERVAL = 4;
  localparam int P_NMI_SEL = 5;
  // vector table
  localparam logic [15:0] VEC_BASE = 16'hFFE0;
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam int N_PRIO = 16;
  localparam logic [3:0] PRIO_RESET = 4'hF;
  localparam logic [3:0] PRIO_NMI = 4'hE;
  localparam logic [3:0] PRIO_T5_C0 = 4'hD;
  localparam logic [3:0] PRIO_T5_SH = 4'hC;
  localparam logic [3:0] PRIO_CMP = 4'hB;
  localparam logic [3:0] PRIO_WDT = 4'hA;
  localparam logic [3:0] PRIO_SCAN = 4'h9;
  localparam logic [3:0] PRIO_T3_C0 = 4'h6;
  localparam logic [3:0] PRIO_T3_SH = 4'h5;
  localparam logic [3:0] PRIO_P1 = 4'h4;
  localparam logic [3:0] PRIO_P2 = 4'h1;
  localparam logic [3:0] PRIO_BT = 4'h0;

  typedef enum logic [2:0] {
    FULL_RUN_MODE = 3'b000,
    SLEEP_LEVEL_0 = 3'b001,
    SLEEP_LEVEL_1 = 3'b011,
    SLEEP_LEVEL_2 = 3'b010,
    SLEEP_LEVEL_3 = 3'b110,
    SLEEP_LEVEL_4 = 3'b111
  } ivs_mode_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SLEEP = 2'b01,
    ST_SERVE = 2'b11
  } ivs_state_t;

  typedef struct packed {
    logic cpu_run;
    logic main_clk_on;
    logic sub_clk_on;
    logic aux_clk_on;
    logic freq_lock_loop_on;
    logic controlled_osc_clock_on;
    logic osc_dc_gen_on;
    logic crystal_on;
  } ivs_clk_t;

  typedef struct packed {
    logic power_up;
    logic ext_reset;
    logic watchdog_expiry;
    logic flash_key_violation;
    logic nmi_pin_event;
    logic osc_fault;
    logic flash_violation;
    logic watchdog_interval;
  } ivs_sys_t;

  typedef struct packed {
    logic t5_c0;
    logic [4:0] t5_shared;
    logic comparator_flag;
    logic [6:0] scan_if_flags;
    logic t3_c0;
    logic [2:0] t3_shared;
    logic [7:0] port_one_change_flags;
    logic [7:0] port_two_change_flags;
    logic basic_tick;
  } ivs_periph_t;
endpackage
